// ===== testbench/mic_mac_model.sv
// Receive-side MAC partner: one frame of carrier, then a data tail
`timescale 1ns/1ns
module mic_mac_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic go,
  output logic carrier_sense,
  output logic rx_data_valid,
  output logic rmii_beat
);
  int cnt;
  // Carrier drops six cycles before data ends, the case where revisions differ
  assign carrier_sense = cnt > 6;
  assign rx_data_valid = cnt > 0;
  always @(posedge clock) begin
    rmii_beat <= !reset && !rmii_beat;
    if (reset) begin
      cnt <= 0;
    end else if (go) begin
      cnt <= 18;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule // mic_mac_model

// ===== testbench/testbench.sv
// Self-checking bench for the MAC interface control and interrupt status slice
`timescale 1ns/1ns
module testbench;
  logic clock, reset, read, write, go, crs_chk, exp_crs, rev_m;
  logic [4:0] ev;
  logic [3:0] be;
  logic [4:0] strap;
  logic [9:0] address;
  logic [31:0] writedata, readdata, lf;
  logic waitrequest, rx_dly, tx_dly, clk50, crs_dv, irq, cs, dv, beat;
  mic_pkg::mic_mode_t mac_mode;
  logic [3:0] thr_b;
  logic [2:0] tol_b;
  logic [13:0] max_b;
  logic [15:0] rd;
  int err_count, n_tests, cyc, ctrl_m, st_m, en_m, pend_m;
  int thr_t[4] = '{5, 2, 6, 10};
  int tol_t[4] = '{5, 2, 3, 2};
  int len_t[4] = '{8750, 1250, 6250, 1250};

  mic_regs u_mic_regs (.clock(clock), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
    .waitrequest(waitrequest), .strap_rx_delay(strap[0]), .strap_tx_delay(strap[1]),
    .strap_rgmii(strap[2]), .strap_clk50(strap[3]), .strap_rmii(strap[4]),
    .por_done_event(ev[0]), .no_frame_event(ev[1]), .sleep_signal_event(ev[2]),
    .fifo_overflow_event(ev[3]), .fifo_underflow_event(ev[4]), .carrier_sense(cs),
    .rx_data_valid(dv), .rmii_beat(beat), .mac_mode(mac_mode), .rx_clk_delay_en(rx_dly),
    .tx_clk_delay_en(tx_dly), .ref_clk_50m(clk50), .sgmii_threshold_bits(thr_b),
    .elastic_tolerance_bits(tol_b), .elastic_max_bytes(max_b), .crs_dv(crs_dv), .irq(irq));
  mic_mac_model u_mic_mac_model (.clock(clock), .reset(reset), .go(go),
    .carrier_sense(cs), .rx_data_valid(dv), .rmii_beat(beat));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic xirq();
    return (pend_m[12] & en_m[4]) | (pend_m[11] & en_m[3]) | (pend_m[8] & en_m[0]);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int n;
    logic [15:0] m;
    n = 0;
    @(posedge clock);
    address <= {idx, 2'h0};
    write <= wr;
    read <= !wr;
    writedata <= {16'h0000, wd};
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    chk(waitrequest, 0);
    rd = readdata[15:0];
    m = {{8{be[1]}}, {8{be[0]}}};
    read <= 1'b0;
    write <= 1'b0;
    if (wr && idx == mic_pkg::MIC_IDX_CTRL) ctrl_m = (ctrl_m & ~m) | (wd & m & 16'h7FF3);
    if (wr && idx == mic_pkg::MIC_IDX_STAT3 && be[0]) en_m = wd & 16'h001F;
  endtask

  task automatic rdchk(input logic [7:0] idx, input int exp);
    bus(1'b0, idx, 16'h0000);
    chk(rd, exp);
    if (idx == mic_pkg::MIC_IDX_CTRL) st_m = 12;
    if (idx == mic_pkg::MIC_IDX_STAT3) pend_m = 0;
  endtask

  task automatic outs();
    repeat (2) @(posedge clock);
    #1;
    chk(mac_mode, ctrl_m[9] ? 3 : ctrl_m[5] ? 1 : 0);
    chk(rx_dly, ctrl_m[12]);
    chk(tx_dly, ctrl_m[11]);
    chk(clk50, ctrl_m[7]);
    chk(thr_b, thr_t[ctrl_m[14:13]]);
    chk(tol_b, tol_t[ctrl_m[1:0]]);
    chk(max_b, len_t[ctrl_m[1:0]]);
    chk(irq, xirq());
  endtask

  task automatic pulse(input int k);
    @(posedge clock);
    ev <= 5'(1 << k);
    @(posedge clock);
    ev <= 5'h00;
    #1;
    if (k < 3) pend_m = pend_m | (k == 0 ? 4096 : k == 1 ? 2048 : 256);
    else st_m = st_m & (k == 3 ? 4 : 8);
    chk(irq, xirq());
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end

  always @(posedge clock) begin
    if (crs_chk) chk(crs_dv, exp_crs);
    exp_crs <= rev_m ? (cs | dv) : cs ? 1'b1 : dv ? (exp_crs ^ beat) : 1'b0;
  end

  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    go = 1'b0;
    be = 4'h3;
    ev = 5'h00;
    crs_chk = 1'b0;
    rev_m = 1'b0;
    address = 10'h000;
    writedata = 32'h00000000;
    pend_m = 0;
    st_m = 0;
    en_m = 16;
    lf = lfsr(32'he4be);
    strap = lf[6:2];
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    ctrl_m = 'h4041 | strap[0] << 12 | strap[1] << 11 | strap[2] << 9 | strap[3] << 7
      | strap[4] << 5;
    rdchk(mic_pkg::MIC_IDX_CTRL, ctrl_m);
    outs();
    rdchk(mic_pkg::MIC_IDX_STAT3, 16);
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      bus(1'b1, mic_pkg::MIC_IDX_CTRL, (lf[15:0] & 16'h9FFC) | 16'(i % 4) << 13 | 16'(i / 4));
      outs();
      rdchk(mic_pkg::MIC_IDX_CTRL, ctrl_m | st_m);
    end
    // Lane enables: only the enabled byte of a write lands
    be <= 4'h1;
    bus(1'b1, mic_pkg::MIC_IDX_CTRL, 16'(ctrl_m ^ 'h7FFF));
    be <= 4'h2;
    bus(1'b1, mic_pkg::MIC_IDX_STAT3, 16'h001F);
    be <= 4'h3;
    outs();
    rdchk(mic_pkg::MIC_IDX_CTRL, ctrl_m | st_m);
    rdchk(mic_pkg::MIC_IDX_STAT3, en_m);
    // Unmapped word: writes dropped, reads zero
    bus(1'b1, 8'h19, 16'hFFFF);
    rdchk(8'h19, 0);
    rdchk(mic_pkg::MIC_IDX_CTRL, ctrl_m | st_m);
    for (int k = 3; k < 5; k++) begin
      pulse(k);
      rdchk(mic_pkg::MIC_IDX_CTRL, ctrl_m | st_m);
      rdchk(mic_pkg::MIC_IDX_CTRL, ctrl_m | st_m);
    end
    for (int k = 0; k < 3; k++) begin
      lf = lfsr(lf);
      bus(1'b1, mic_pkg::MIC_IDX_STAT3, lf[15:0]);
      pulse(k);
      repeat (5) @(posedge clock);
      outs();
      bus(1'b1, mic_pkg::MIC_IDX_STAT3, 16'h001F);
      outs();
      rdchk(mic_pkg::MIC_IDX_STAT3, pend_m | en_m);
      outs();
      rdchk(mic_pkg::MIC_IDX_STAT3, en_m);
    end
    for (int r = 1; r >= 0; r--) begin
      bus(1'b1, mic_pkg::MIC_IDX_CTRL, 16'((ctrl_m & ~16) | r << 4));
      rev_m <= r[0];
      repeat (4) @(posedge clock);
      crs_chk <= 1'b1;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (30) @(posedge clock);
      crs_chk <= 1'b0;
    end
    summarize();
  end
endmodule // testbench

// ===== verilog/mic_pkg.sv
// Package for the MAC interface control and interrupt status slice
package mic_pkg;
  // Printed offsets are word indices; byte address is four times the index
  localparam logic [7:0] MIC_IDX_CTRL = 8'h17;
  localparam logic [7:0] MIC_IDX_STAT3 = 8'h18;
  // Control register field positions
  localparam int MIC_B_THR = 13;
  localparam int MIC_B_RXDLY = 12;
  localparam int MIC_B_TXDLY = 11;
  localparam int MIC_B_RSV10 = 10;
  localparam int MIC_B_RGMII = 9;
  localparam int MIC_B_RSV8 = 8;
  localparam int MIC_B_CLK50 = 7;
  localparam int MIC_B_RSV6 = 6;
  localparam int MIC_B_RMII = 5;
  localparam int MIC_B_REV10 = 4;
  localparam int MIC_B_OVF = 3;
  localparam int MIC_B_UNF = 2;
  localparam int MIC_B_ELAS = 0;
  // Interrupt status register field positions
  localparam int MIC_B_POR = 12;
  localparam int MIC_B_NOF = 11;
  localparam int MIC_B_SLP = 8;
  localparam int MIC_B_POR_EN = 4;
  localparam int MIC_B_NOF_EN = 3;
  localparam int MIC_B_ERSV = 1;
  localparam int MIC_B_SLP_EN = 0;
  // Reset values
  localparam logic [1:0] MIC_RST_THR = 2'h2;
  localparam logic MIC_RST_RSV6 = 1'b1;
  localparam logic [1:0] MIC_RST_ELAS = 2'h1;
  localparam logic [2:0] MIC_RST_EN = 3'h4;
  // Threshold in bits per code 00,01,10,11
  localparam logic [3:0] MIC_THR_00 = 4'h5;
  localparam logic [3:0] MIC_THR_01 = 4'h2;
  localparam logic [3:0] MIC_THR_10 = 4'h6;
  localparam logic [3:0] MIC_THR_11 = 4'hA;
  // Elasticity tolerance in bits and largest packet in bytes
  localparam logic [2:0] MIC_TOL_00 = 3'h5;
  localparam logic [2:0] MIC_TOL_01 = 3'h2;
  localparam logic [2:0] MIC_TOL_10 = 3'h3;
  localparam logic [13:0] MIC_LEN_00 = 14'h222E;
  localparam logic [13:0] MIC_LEN_01 = 14'h04E2;
  localparam logic [13:0] MIC_LEN_10 = 14'h186A;
  // Internal RGMII clock skew, realised by a pad delay cell
  localparam int MIC_RGMII_DELAY_PS = 2000;

  // Gray coded along MII, RMII, RGMII
  typedef enum logic [1:0] {
    MIC_MODE_MII = 2'h0,
    MIC_MODE_RMII = 2'h1,
    MIC_MODE_RGMII = 2'h3
  } mic_mode_t;

  typedef struct packed {
    logic [1:0] thr;
    logic rx_dly;
    logic tx_dly;
    logic rsv10;
    logic rgmii;
    logic rsv8;
    logic clk50;
    logic rsv6;
    logic rmii;
    logic rev10;
    logic [1:0] elas;
  } mic_ctrl_t;

  typedef struct packed {
    mic_ctrl_t ctrl;
    logic ovf_seen;
    logic unf_seen;
    logic [2:0] pend;
    logic [2:0] en;
    logic [1:0] en_rsv;
    logic strap_done;
    logic ack;
    logic [15:0] rdata;
    mic_mode_t mode;
    logic [3:0] thr_bits;
    logic [2:0] tol_bits;
    logic [13:0] tol_bytes;
    logic irq;
    logic crs_dv;
  } mic_state_t;
endpackage

// ===== verilog/mic_regs.sv
// MAC interface control and third interrupt status registers on Avalon-MM
`timescale 1ns/1ns
// Overview of operation
// - SGMII buffer half-full threshold field: 00=5,01=2,10=6,11=10 bits; resets to 10.
// - RGMII receive delay bit 1 delays receive clock 2 ns; 0 edge-aligned.
// - RGMII transmit delay bit 1 delays transmit clock 2 ns; 0 aligned.
// - RGMII enable bit 1 selects RGMII; 0 defers to the RMII select bit.
// - Without RGMII, RMII select 1 gives RMII, 0 gives MII.
// - Reference clock select is strap loaded: 1 is 50 MHz, 0 is 25 MHz.
// - RMII revision 1.0: CRS_DV stays asserted until last data, no toggling.
// - RMII revision 1.2, the default: CRS_DV toggles at packet end.
// - Receive FIFO overflow status is clear on read; reads 0 when detected.
// - Receive FIFO underflow status is clear on read; reads 0 when detected.
// - Elasticity buffer field: 00=5 bits,01=2 bits,10=3 bits; resets to 01.
// - Elasticity buffer absorbs RMII clock offset; smallest setting handles packets up to 1250 bytes.
// - Reset-done event latches pending flag at status bit 12.
// - No-frame-detected event latches pending flag at bit 11.
// - Sleep-signal event latches pending flag at bit 8.
// - Read-write enable at bit 4 for reset-done interrupt, resets to 1.
// - Read-write enable at bit 3 for no-frame interrupt, resets to 0.
// - Read-write enable at bit 0 for sleep-signal interrupt, resets to 0.
module mic_regs #(
  parameter int ADDR_W = 10
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic strap_rx_delay,
  input wire logic strap_tx_delay,
  input wire logic strap_rgmii,
  input wire logic strap_clk50,
  input wire logic strap_rmii,
  input wire logic por_done_event,
  input wire logic no_frame_event,
  input wire logic sleep_signal_event,
  input wire logic fifo_overflow_event,
  input wire logic fifo_underflow_event,
  input wire logic carrier_sense,
  input wire logic rx_data_valid,
  input wire logic rmii_beat,
  output mic_pkg::mic_mode_t mac_mode,
  output logic rx_clk_delay_en,
  output logic tx_clk_delay_en,
  output logic ref_clk_50m,
  output logic [3:0] sgmii_threshold_bits,
  output logic [2:0] elastic_tolerance_bits,
  output logic [13:0] elastic_max_bytes,
  output logic crs_dv,
  output logic irq
);
  mic_pkg::mic_state_t st_q;
  mic_pkg::mic_state_t st_d;
  logic [7:0] idx;
  logic sel_ctrl;
  logic sel_stat;
  logic [15:0] rd16;
  logic take;

  assign idx = address[ADDR_W-1:2];
  assign sel_ctrl = (idx == mic_pkg::MIC_IDX_CTRL);
  assign sel_stat = (idx == mic_pkg::MIC_IDX_STAT3);
  // Access completes in the cycle that waitrequest is low
  assign take = st_q.ack & (read | write);

  always_comb begin
    rd16 = 16'h0000;
    if (sel_ctrl) begin
      rd16[mic_pkg::MIC_B_THR +: 2] = st_q.ctrl.thr;
      rd16[mic_pkg::MIC_B_RXDLY] = st_q.ctrl.rx_dly;
      rd16[mic_pkg::MIC_B_TXDLY] = st_q.ctrl.tx_dly;
      rd16[mic_pkg::MIC_B_RSV10] = st_q.ctrl.rsv10;
      rd16[mic_pkg::MIC_B_RGMII] = st_q.ctrl.rgmii;
      rd16[mic_pkg::MIC_B_RSV8] = st_q.ctrl.rsv8;
      rd16[mic_pkg::MIC_B_CLK50] = st_q.ctrl.clk50;
      rd16[mic_pkg::MIC_B_RSV6] = st_q.ctrl.rsv6;
      rd16[mic_pkg::MIC_B_RMII] = st_q.ctrl.rmii;
      rd16[mic_pkg::MIC_B_REV10] = st_q.ctrl.rev10;
      rd16[mic_pkg::MIC_B_OVF] = ~st_q.ovf_seen;
      rd16[mic_pkg::MIC_B_UNF] = ~st_q.unf_seen;
      rd16[mic_pkg::MIC_B_ELAS +: 2] = st_q.ctrl.elas;
    end else if (sel_stat) begin
      rd16[mic_pkg::MIC_B_POR] = st_q.pend[2];
      rd16[mic_pkg::MIC_B_NOF] = st_q.pend[1];
      rd16[mic_pkg::MIC_B_SLP] = st_q.pend[0];
      rd16[mic_pkg::MIC_B_POR_EN] = st_q.en[2];
      rd16[mic_pkg::MIC_B_NOF_EN] = st_q.en[1];
      rd16[mic_pkg::MIC_B_ERSV +: 2] = st_q.en_rsv;
      rd16[mic_pkg::MIC_B_SLP_EN] = st_q.en[0];
    end
  end

  always_comb begin
    st_d = st_q;
    // One wait state; read data are sampled before any side effect
    st_d.ack = (read | write) & ~st_q.ack;
    if ((read | write) & ~st_q.ack) begin
      st_d.rdata = read ? rd16 : 16'h0000;
    end
    // Straps land on the first edge after reset release
    if (!st_q.strap_done) begin
      st_d.strap_done = 1'b1;
      st_d.ctrl.rx_dly = strap_rx_delay;
      st_d.ctrl.tx_dly = strap_tx_delay;
      st_d.ctrl.rgmii = strap_rgmii;
      st_d.ctrl.clk50 = strap_clk50;
      st_d.ctrl.rmii = strap_rmii;
    end
    if (take & write & sel_ctrl) begin
      if (byteenable[1]) begin
        st_d.ctrl.thr = writedata[mic_pkg::MIC_B_THR +: 2];
        st_d.ctrl.rx_dly = writedata[mic_pkg::MIC_B_RXDLY];
        st_d.ctrl.tx_dly = writedata[mic_pkg::MIC_B_TXDLY];
        st_d.ctrl.rsv10 = writedata[mic_pkg::MIC_B_RSV10];
        st_d.ctrl.rgmii = writedata[mic_pkg::MIC_B_RGMII];
        st_d.ctrl.rsv8 = writedata[mic_pkg::MIC_B_RSV8];
      end
      if (byteenable[0]) begin
        st_d.ctrl.clk50 = writedata[mic_pkg::MIC_B_CLK50];
        st_d.ctrl.rsv6 = writedata[mic_pkg::MIC_B_RSV6];
        st_d.ctrl.rmii = writedata[mic_pkg::MIC_B_RMII];
        st_d.ctrl.rev10 = writedata[mic_pkg::MIC_B_REV10];
        st_d.ctrl.elas = writedata[mic_pkg::MIC_B_ELAS +: 2];
      end
    end
    if (take & write & sel_stat & byteenable[0]) begin
      st_d.en[2] = writedata[mic_pkg::MIC_B_POR_EN];
      st_d.en[1] = writedata[mic_pkg::MIC_B_NOF_EN];
      st_d.en_rsv = writedata[mic_pkg::MIC_B_ERSV +: 2];
      st_d.en[0] = writedata[mic_pkg::MIC_B_SLP_EN];
    end
    // Clear only what the read reported, so an event after sampling survives
    if (take & read & sel_ctrl) begin
      if (!st_q.rdata[mic_pkg::MIC_B_OVF]) begin
        st_d.ovf_seen = 1'b0;
      end
      if (!st_q.rdata[mic_pkg::MIC_B_UNF]) begin
        st_d.unf_seen = 1'b0;
      end
    end
    if (take & read & sel_stat) begin
      st_d.pend = st_q.pend & ~{st_q.rdata[mic_pkg::MIC_B_POR],
                                st_q.rdata[mic_pkg::MIC_B_NOF],
                                st_q.rdata[mic_pkg::MIC_B_SLP]};
    end
    // Set wins over clear
    st_d.ovf_seen = st_d.ovf_seen | fifo_overflow_event;
    st_d.unf_seen = st_d.unf_seen | fifo_underflow_event;
    st_d.pend[2] = st_d.pend[2] | por_done_event;
    st_d.pend[1] = st_d.pend[1] | no_frame_event;
    st_d.pend[0] = st_d.pend[0] | sleep_signal_event;
    st_d.irq = |(st_d.pend & st_d.en);
    // Derived controls follow the next register value, so outputs are flops
    if (st_d.ctrl.rgmii) begin
      st_d.mode = mic_pkg::MIC_MODE_RGMII;
    end else if (st_d.ctrl.rmii) begin
      st_d.mode = mic_pkg::MIC_MODE_RMII;
    end else begin
      st_d.mode = mic_pkg::MIC_MODE_MII;
    end
    unique case (st_d.ctrl.thr)
      2'h0: st_d.thr_bits = mic_pkg::MIC_THR_00;
      2'h1: st_d.thr_bits = mic_pkg::MIC_THR_01;
      2'h2: st_d.thr_bits = mic_pkg::MIC_THR_10;
      2'h3: st_d.thr_bits = mic_pkg::MIC_THR_11;
    endcase
    // Code 11 has no defined depth; it falls back to the smallest one
    unique case (st_d.ctrl.elas)
      2'h0: begin
        st_d.tol_bits = mic_pkg::MIC_TOL_00;
        st_d.tol_bytes = mic_pkg::MIC_LEN_00;
      end
      2'h2: begin
        st_d.tol_bits = mic_pkg::MIC_TOL_10;
        st_d.tol_bytes = mic_pkg::MIC_LEN_10;
      end
      default: begin
        st_d.tol_bits = mic_pkg::MIC_TOL_01;
        st_d.tol_bytes = mic_pkg::MIC_LEN_01;
      end
    endcase
    // Revision 1.0 holds CRS_DV through the drain; 1.2 toggles it per beat
    if (st_q.ctrl.rev10) begin
      st_d.crs_dv = carrier_sense | rx_data_valid;
    end else if (carrier_sense) begin
      st_d.crs_dv = 1'b1;
    end else if (rx_data_valid) begin
      if (rmii_beat) begin
        st_d.crs_dv = ~st_q.crs_dv;
      end
    end else begin
      st_d.crs_dv = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= '0;
      st_q.ctrl.thr <= mic_pkg::MIC_RST_THR;
      st_q.ctrl.rsv6 <= mic_pkg::MIC_RST_RSV6;
      st_q.ctrl.elas <= mic_pkg::MIC_RST_ELAS;
      st_q.ovf_seen <= 1'b1;
      st_q.unf_seen <= 1'b1;
      st_q.en <= mic_pkg::MIC_RST_EN;
      st_q.thr_bits <= mic_pkg::MIC_THR_10;
      st_q.tol_bits <= mic_pkg::MIC_TOL_01;
      st_q.tol_bytes <= mic_pkg::MIC_LEN_01;
    end else begin
      st_q <= st_d;
    end
  end

  assign readdata = {16'h0000, st_q.rdata};
  assign waitrequest = ~st_q.ack;
  assign mac_mode = st_q.mode;
  assign rx_clk_delay_en = st_q.ctrl.rx_dly;
  assign tx_clk_delay_en = st_q.ctrl.tx_dly;
  assign ref_clk_50m = st_q.ctrl.clk50;
  assign sgmii_threshold_bits = st_q.thr_bits;
  assign elastic_tolerance_bits = st_q.tol_bits;
  assign elastic_max_bytes = st_q.tol_bytes;
  assign crs_dv = st_q.crs_dv;
  assign irq = st_q.irq;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  thr_map_a: assert property (st_q.strap_done |-> sgmii_threshold_bits ==
      ((st_q.ctrl.thr == 2'h0) ? 4'h5 : (st_q.ctrl.thr == 2'h1) ? 4'h2 :
       (st_q.ctrl.thr == 2'h2) ? 4'h6 : 4'hA))
    else $error("threshold does not match field");
  rx_delay_a: assert property (take && write && sel_ctrl && byteenable[1]
      |=> rx_clk_delay_en == $past(writedata[12]))
    else $error("rx delay not taken from write");
  tx_delay_a: assert property (take && write && sel_ctrl && byteenable[1]
      |=> tx_clk_delay_en == $past(writedata[11]))
    else $error("tx delay not taken from write");
  rgmii_mode_a: assert property (st_q.ctrl.rgmii |-> mac_mode == mic_pkg::MIC_MODE_RGMII)
    else $error("rgmii bit set but mode differs");
  rmii_mii_a: assert property (!st_q.ctrl.rgmii |->
      mac_mode == (st_q.ctrl.rmii ? mic_pkg::MIC_MODE_RMII : mic_pkg::MIC_MODE_MII))
    else $error("rmii or mii mode wrong");
  strap_load_a: assert property ($rose(st_q.strap_done) |->
      ref_clk_50m == $past(strap_clk50))
    else $error("clock select strap not loaded");
  rev10_hold_a: assert property (st_q.ctrl.rev10 |=>
      crs_dv == $past(carrier_sense | rx_data_valid))
    else $error("rev 1.0 crs_dv wrong");
  rev12_toggle_a: assert property (!st_q.ctrl.rev10 && !carrier_sense && rx_data_valid
      && rmii_beat |=> crs_dv != $past(crs_dv))
    else $error("rev 1.2 crs_dv did not toggle");
  ovf_flag_a: assert property (fifo_overflow_event |=> st_q.ovf_seen [*2] or
      (st_q.ovf_seen ##1 !st_q.ovf_seen))
    else $error("overflow not latched");
  unf_flag_a: assert property (fifo_underflow_event |=> st_q.unf_seen)
    else $error("underflow not latched");
  elas_map_a: assert property (st_q.ctrl.elas == 2'h0 |->
      elastic_tolerance_bits == 3'h5 && elastic_max_bytes == 14'h222E)
    else $error("elasticity depth wrong");
  por_latch_a: assert property (por_done_event |=> st_q.pend[2])
    else $error("reset-done flag not set");
  nof_latch_a: assert property (no_frame_event |=> st_q.pend[1])
    else $error("no-frame flag not set");
  slp_latch_a: assert property (sleep_signal_event |=> st_q.pend[0])
    else $error("sleep flag not set");
  pend_hold_a: assert property (st_q.pend[2] && !(take && read && sel_stat)
      |=> st_q.pend[2])
    else $error("pending flag lost without read");
  irq_gate_a: assert property (irq == |(st_q.pend & st_q.en))
    else $error("interrupt does not follow flags");
  bus_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered in one wait state");
  bus_once_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  strap_dly_a: assert property ($rose(st_q.strap_done) |->
      rx_clk_delay_en == $past(strap_rx_delay) && tx_clk_delay_en == $past(strap_tx_delay))
    else $error("delay straps not loaded");
  strap_mode_a: assert property ($rose(st_q.strap_done) |->
      st_q.ctrl.rgmii == $past(strap_rgmii) && st_q.ctrl.rmii == $past(strap_rmii))
    else $error("mode straps not loaded");
  elas_small_a: assert property (st_q.ctrl.elas[0] |->
      elastic_tolerance_bits == 3'h2 && elastic_max_bytes == 14'h04E2)
    else $error("smallest elasticity depth wrong");
  elas_mid_a: assert property (st_q.ctrl.elas == 2'h2 |->
      elastic_tolerance_bits == 3'h3 && elastic_max_bytes == 14'h186A)
    else $error("middle elasticity depth wrong");
  ovf_clear_a: assert property (take && read && sel_ctrl && !fifo_overflow_event
      && !st_q.rdata[mic_pkg::MIC_B_OVF] |=> !st_q.ovf_seen)
    else $error("overflow status not cleared by read");
  unf_clear_a: assert property (take && read && sel_ctrl && !fifo_underflow_event
      && !st_q.rdata[mic_pkg::MIC_B_UNF] |=> !st_q.unf_seen)
    else $error("underflow status not cleared by read");
  pend_clear_a: assert property (take && read && sel_stat && !por_done_event
      && st_q.rdata[mic_pkg::MIC_B_POR] |=> !st_q.pend[2])
    else $error("pending flag not cleared by read");
  nof_hold_a: assert property (st_q.pend[1] && !(take && read && sel_stat)
      |=> st_q.pend[1])
    else $error("no-frame flag lost without read");
  slp_hold_a: assert property (st_q.pend[0] && !(take && read && sel_stat)
      |=> st_q.pend[0])
    else $error("sleep flag lost without read");
  en_write_a: assert property (take && write && sel_stat && byteenable[0]
      |=> st_q.en[1] == $past(writedata[mic_pkg::MIC_B_NOF_EN])
      && st_q.en[0] == $past(writedata[mic_pkg::MIC_B_SLP_EN]))
    else $error("interrupt enables not taken from write");

  stat_read_c: cover property (take && read && sel_stat && st_q.rdata[12]);
  rgmii_on_c: cover property (mac_mode == mic_pkg::MIC_MODE_RGMII);
  toggle_c: cover property (!st_q.ctrl.rev10 && !carrier_sense && rx_data_valid && rmii_beat);
  ovf_clear_c: cover property (st_q.ovf_seen ##1 !st_q.ovf_seen);
endmodule // mic_regs
